/* logic/rxf_pkg.sv */
// What this block does
// - receive buffer is one 16-bit register
// - flag when bit count reaches threshold 1..15
// - host should program threshold of eight or more; rxf_dev flags at any level 1..15 and the testbench fills at level 1
// - sync-gated mode fills only after valid data
// - store each bit following the sync pattern while valid data holds
// - sync pattern fixed at 2dd4, not programmable
// - valid-data output rises when pattern found
// - host toggles select; data on next clock
// - level flag stays high until last bit out
// - level flag rises when count equals threshold
// - status read shifts status bits before data
// - frequency adjust enable, auto or strobe mode
// - limited offset added to synthesizer control word
// - crystal load 8.5pF to 16pF, 0.5pF steps
// - host clock: eight dividers of reference
// - oscillator off stops host clock output
// - 196 more output clocks before stopping
// - host recalibrates synthesizer after band change
// - count noise spikes, threshold zero to seven
// - validity: quality, lock, strength (slow); quality, lock (medium); strength (fast)
// - slow, medium, fast detector modes
// - detector off passes raw comparator data
// - buffer disabled routes data and clock to pins
package rxf_pkg;
  localparam int          BUF_W          = 16;
  localparam logic [15:0] SYNC_WORD      = 16'h2dd4;
  localparam logic [3:0]  THRESH_RST     = 4'h8;
  localparam int          CLK_HOLD_CYC   = 196;
  localparam int          DQD_WINDOW     = 16;
  localparam logic [7:0]  FSK_MIN_PREAMB_SLOW = 8'h10;
  localparam logic [7:0]  FSK_MIN_PREAMB_MED  = 8'h08;
  localparam logic [7:0]  FSK_MIN_PREAMB_FAST = 8'h04;
  localparam logic [15:0] STATUS_W_RST   = 16'h0000;
  localparam logic [3:0]  CAP_RST        = 4'h8;
  localparam logic [9:0]  FCW_RST        = 10'h000;
  // apb register offsets of the host controller
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_STAT       = 8'h04;
  localparam logic [7:0]  REG_DATA       = 8'h08;
  localparam logic [7:0]  REG_CMD        = 8'h0c;
  // control register fields
  localparam int          CTRL_START     = 0;
  localparam int          CTRL_USESTAT   = 1;
  localparam int          SPI_HALF       = 2;
  typedef enum logic [1:0] {VD_SLOW, VD_MED, VD_FAST} rxf_vd_mode_type;
endpackage

/* logic/rxf_link_if.sv */
`timescale 1ns/1ps
// pins between radio receive path and host controller
interface rxf_link_if;
  logic sck;
  logic buffer_select_n;
  logic sdo;
  logic buffer_level_flag;
  logic valid_data;
  logic stat_req;
  modport dev  (input sck, buffer_select_n, stat_req, output sdo, buffer_level_flag, valid_data);
  modport host (output sck, buffer_select_n, stat_req, input sdo, buffer_level_flag, valid_data);
endinterface

/* logic/rxf_quality.sv */
`timescale 1ns/1ps
// noise spike counting and valid-data decision
module rxf_quality (
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  input  wire logic                     bit_stb_i,
  input  wire logic                     raw_bit_i,
  input  wire logic                     cr_lock_i,
  input  wire logic                     rssi_i,
  input  wire logic [2:0]               dqd_thresh_i,
  input  wire logic                     vd_en_i,
  input  wire rxf_pkg::rxf_vd_mode_type vd_mode_i,
  output logic                          dqd_good_o,
  output logic                          vd_ok_o
);
  typedef struct packed {
    logic [4:0] win;
    logic [4:0] spikes;
    logic       prev;
    logic       good;
    logic [7:0] preamb;
    logic       ok;
  } rxf_q_st_type;
  rxf_q_st_type s_r, s_nxt;

  // spikes counted per window, compared to threshold; preamble count gates validity
  always_comb begin
    s_nxt = s_r;
    if (bit_stb_i) begin
      s_nxt.prev = raw_bit_i;
      s_nxt.preamb = (raw_bit_i != s_r.prev) ? ((s_r.preamb == 8'hff) ? s_r.preamb : s_r.preamb + 8'h01) : 8'h00;
      if (raw_bit_i == s_r.prev)
        s_nxt.spikes = s_r.spikes + 5'h01;
      s_nxt.win = s_r.win + 5'h01;
      if (s_r.win == 5'(rxf_pkg::DQD_WINDOW - 1)) begin
        s_nxt.good = (s_r.spikes[4:3] == 2'h0) && (s_r.spikes[2:0] <= dqd_thresh_i);
        s_nxt.win = 5'h00;
        s_nxt.spikes = 5'h00;
      end
      case (vd_mode_i)
        rxf_pkg::VD_SLOW: s_nxt.ok = s_r.good && cr_lock_i && rssi_i && (s_r.preamb >= rxf_pkg::FSK_MIN_PREAMB_SLOW);
        rxf_pkg::VD_MED:  s_nxt.ok = s_r.good && cr_lock_i && (s_r.preamb >= rxf_pkg::FSK_MIN_PREAMB_MED);
        rxf_pkg::VD_FAST: s_nxt.ok = rssi_i && (s_r.preamb >= rxf_pkg::FSK_MIN_PREAMB_FAST);
        default:          s_nxt.ok = 1'b0;
      endcase
    end
    if (!vd_en_i)
      s_nxt.ok = 1'b1;
  end

  // state register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign dqd_good_o = s_r.good;
  assign vd_ok_o    = s_r.ok;
endmodule

/* logic/rxf_dev.sv */
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
// radio-side receive buffer, sync detector, frequency trim and clock output
module rxf_dev (
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  rxf_link_if.dev                       link,
  input  wire logic                     bit_stb_i,
  input  wire logic                     raw_bit_i,
  input  wire logic                     cr_lock_i,
  input  wire logic                     rssi_i,
  input  wire logic                     rx_buffer_enable_i,
  input  wire logic                     sync_gate_i,
  input  wire logic [3:0]               thresh_i,
  input  wire logic [2:0]               dqd_thresh_i,
  input  wire logic                     vd_en_i,
  input  wire rxf_pkg::rxf_vd_mode_type vd_mode_i,
  input  wire logic                     vd_pin_sel_i,
  input  wire logic                     afa_en_i,
  input  wire logic                     afa_auto_i,
  input  wire logic                     afa_strobe_i,
  input  wire logic [4:0]               afa_meas_i,
  input  wire logic [1:0]               afa_range_i,
  input  wire logic [9:0]               fcw_i,
  input  wire logic [3:0]               cap_i,
  input  wire logic [2:0]               clk_div_sel_i,
  input  wire logic                     osc_en_i,
  input  wire logic [15:0]              status_bits_i,
  output logic                          data_pin_o,
  output logic                          rclk_pin_o,
  output logic [9:0]                    fcw_o,
  output logic [4:0]                    afa_off_o,
  output logic [4:0]                    cap_load_o,
  output logic                          host_clk_o
);
  typedef struct packed {
    logic [15:0] shreg;
    logic [15:0] buffer;
    logic [4:0]  count;
    logic        synced;
    logic        flag;
    logic        vd_pin;
    logic        sel_d;
    logic        sck_d;
    logic [4:0]  rd_left;
    logic [4:0]  stat_cnt;
    logic        sdo;
    logic [4:0]  off;
    logic [9:0]  fcw;
    logic        data_pin;
    logic        rclk_pin;
    logic [7:0]  div_cnt;
    logic        hclk;
    logic [7:0]  hold_cnt;
    logic        hold_run;
    logic        hclk_on;
  } rxf_dev_st_type;
  rxf_dev_st_type s_r, s_nxt;

  logic dqd_good;
  logic flag_set;
  logic vd_ok;
  logic [7:0] div_lim;

  // data quality and validity screening
  rxf_quality u_q (
    .core_clk_i   (core_clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .bit_stb_i    (bit_stb_i),
    .raw_bit_i    (raw_bit_i),
    .cr_lock_i    (cr_lock_i),
    .rssi_i       (rssi_i),
    .dqd_thresh_i (dqd_thresh_i),
    .vd_en_i      (vd_en_i),
    .vd_mode_i    (vd_mode_i),
    .dqd_good_o   (dqd_good),
    .vd_ok_o      (vd_ok)
  );

  // clamp an offset to the programmed range
  function automatic logic [4:0] clamp_off(input logic [4:0] v, input logic [1:0] rng);
    logic [4:0] lim;
    lim = 5'(5'h01 << rng) + 5'h01;
    if (!v[4] && v > lim)
      clamp_off = lim;
    else if (v[4] && (5'(~v + 5'h01) > lim))
      clamp_off = 5'(~lim + 5'h01);
    else
      clamp_off = v;
  endfunction

  // host clock divider ratio per select code
  always_comb begin
    case (clk_div_sel_i)
      3'h0: div_lim = 8'h00;
      3'h1: div_lim = 8'h01;
      3'h2: div_lim = 8'h02;
      3'h3: div_lim = 8'h03;
      3'h4: div_lim = 8'h04;
      3'h5: div_lim = 8'h07;
      3'h6: div_lim = 8'h0f;
      default: div_lim = 8'h1f;
    endcase
  end

  // next state
  always_comb begin
    s_nxt = s_r;
    flag_set = 1'b0;
    s_nxt.sel_d = link.buffer_select_n;
    s_nxt.sck_d = link.sck;
    // receive path
    if (bit_stb_i && rx_buffer_enable_i) begin
      s_nxt.shreg = {s_r.shreg[14:0], raw_bit_i};
      if (!s_r.synced && s_nxt.shreg == rxf_pkg::SYNC_WORD && vd_ok) begin
        s_nxt.synced = 1'b1;
        s_nxt.vd_pin = 1'b1;
      end
      if (vd_ok && (s_r.synced || !sync_gate_i)) begin
        s_nxt.buffer = {s_r.buffer[14:0], raw_bit_i};
        if (s_r.count != 5'(rxf_pkg::BUF_W))
          s_nxt.count = s_r.count + 5'h01;
        if (5'(s_r.count + 5'h01) == {1'b0, thresh_i} && thresh_i != 4'h0) begin
          s_nxt.flag = 1'b1;
          flag_set = 1'b1;
        end
      end
    end
    if (!vd_ok) begin
      s_nxt.synced = 1'b0;
      s_nxt.vd_pin = 1'b0;
    end
    s_nxt.data_pin = rx_buffer_enable_i ? 1'b0 : (vd_ok & raw_bit_i);
    s_nxt.rclk_pin = rx_buffer_enable_i ? 1'b0 : bit_stb_i;
    // select toggle starts readout of the buffer
    if (s_r.sel_d && !link.buffer_select_n) begin
      s_nxt.rd_left = s_nxt.count;
      s_nxt.stat_cnt = link.stat_req ? 5'(rxf_pkg::BUF_W) : 5'h00;
    end
    // sdo moves on sck rise, so it is settled before the host samples after the fall
    if (!link.buffer_select_n && !s_r.sck_d && link.sck) begin
      if (s_r.stat_cnt != 5'h00) begin
        s_nxt.sdo = status_bits_i[4'(s_r.stat_cnt - 5'h01)];
        s_nxt.stat_cnt = s_r.stat_cnt - 5'h01;
      end else if (s_r.rd_left != 5'h00) begin
        s_nxt.sdo = s_r.buffer[4'(s_r.rd_left - 5'h01)];
        s_nxt.rd_left = s_r.rd_left - 5'h01;
        s_nxt.count = s_nxt.count - 5'h01;
        if (s_r.rd_left == 5'h01 && !flag_set)
          s_nxt.flag = 1'b0;
      end
    end
    // frequency trim
    if (afa_en_i && (afa_auto_i || afa_strobe_i))
      s_nxt.off = clamp_off(afa_meas_i, afa_range_i);
    s_nxt.fcw = fcw_i + {{5{s_r.off[4]}}, s_r.off};
    if (!afa_en_i)
      s_nxt.fcw = fcw_i;
    // host clock output with hold-off after oscillator stop
    if (osc_en_i) begin
      s_nxt.hold_run = 1'b0;
      s_nxt.hclk_on = 1'b1;
      s_nxt.hold_cnt = 8'h00;
    end else if (s_r.hclk_on && !s_r.hold_run) begin
      s_nxt.hold_run = 1'b1;
    end
    if (s_r.hclk_on) begin
      if (s_r.div_cnt >= div_lim) begin
        s_nxt.div_cnt = 8'h00;
        s_nxt.hclk = ~s_r.hclk;
        if (s_r.hold_run && s_r.hclk) begin
          s_nxt.hold_cnt = s_r.hold_cnt + 8'h01;
          if (s_r.hold_cnt == 8'(rxf_pkg::CLK_HOLD_CYC - 1)) begin
            s_nxt.hclk_on = 1'b0;
            s_nxt.hold_run = 1'b0;
          end
        end
      end else begin
        s_nxt.div_cnt = s_r.div_cnt + 8'h01;
      end
    end else begin
      s_nxt.hclk = 1'b0;
      s_nxt.div_cnt = 8'h00;
    end
  end

  // state register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.sel_d <= 1'b1;
      s_r.fcw <= rxf_pkg::FCW_RST;
      s_r.hclk_on <= 1'b1;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign link.sdo               = s_r.sdo;
  assign link.buffer_level_flag = s_r.flag;
  assign link.valid_data        = vd_pin_sel_i & s_r.vd_pin;
  assign data_pin_o             = s_r.data_pin;
  assign rclk_pin_o             = s_r.rclk_pin;
  assign fcw_o                  = s_r.fcw;
  assign afa_off_o              = s_r.off;
  // load in half-picofarad steps above 8pF: code 1 (8.5pF) to 16 (16pF)
  assign cap_load_o             = 5'(cap_i) + 5'h01;
  assign host_clk_o             = s_r.hclk;
  logic unused_q;
  assign unused_q = dqd_good;
endmodule

/* logic/rxf_host.sv */
`timescale 1ns/1ps
// host controller: reads the buffer over the pins, apb registers for software
module rxf_host (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  rxf_link_if.host         link,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [31:0]      prdata_o
);
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_DONE} rxf_hstate_type;
  typedef struct packed {
    rxf_hstate_type st;
    logic [1:0]     ctrl;
    logic [4:0]     nbits;
    logic [5:0]     left;
    logic [31:0]    data;
    logic           done;
    logic           sel_n;
    logic           sck;
    logic [31:0]    rdata;
    logic           slverr;
  } rxf_h_st_type;
  rxf_h_st_type s_r, s_nxt;
  logic acc;

  assign acc = psel_i & penable_i;

  // register access and readout sequencer
  always_comb begin
    s_nxt = s_r;
    if (psel_i && !penable_i) begin
      s_nxt.slverr = 1'b0;
      case (paddr_i)
        rxf_pkg::REG_CTRL: s_nxt.rdata = {30'h0, s_r.ctrl};
        rxf_pkg::REG_STAT: s_nxt.rdata = {24'h0, link.valid_data, link.buffer_level_flag, s_r.done,
                                          (s_r.st != H_IDLE), 4'h0};
        rxf_pkg::REG_DATA: s_nxt.rdata = s_r.data;
        rxf_pkg::REG_CMD:  s_nxt.rdata = {27'h0, s_r.nbits};
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.slverr = 1'b1;
        end
      endcase
    end
    if (acc && pwrite_i) begin
      case (paddr_i)
        rxf_pkg::REG_CTRL: s_nxt.ctrl = pwdata_i[1:0];
        rxf_pkg::REG_CMD:  s_nxt.nbits = pwdata_i[4:0];
        default: ;
      endcase
      if (paddr_i == rxf_pkg::REG_CTRL && pwdata_i[rxf_pkg::CTRL_START] && s_r.st == H_IDLE) begin
        s_nxt.st = H_LOW;
        s_nxt.sel_n = 1'b0;
        s_nxt.left = 6'(s_r.nbits) + (pwdata_i[rxf_pkg::CTRL_USESTAT] ? 6'(rxf_pkg::BUF_W) : 6'h00);
        s_nxt.data = 32'h0;
        s_nxt.done = 1'b0;
      end
    end
    if (acc && !pwrite_i && paddr_i == rxf_pkg::REG_STAT)
      s_nxt.done = 1'b0;
    case (s_r.st)
      H_IDLE: s_nxt.sck = 1'b0;
      H_LOW: begin
        s_nxt.sck = 1'b1;
        s_nxt.st = H_HIGH;
      end
      H_HIGH: begin
        // sdo moved when the device saw sck rise; it is settled by the next sample
        s_nxt.sck = 1'b0;
        s_nxt.st = H_DONE;
      end
      H_DONE: begin
        s_nxt.data = {s_r.data[30:0], link.sdo};
        s_nxt.left = s_r.left - 6'h01;
        if (s_r.left <= 6'h01) begin
          s_nxt.st = H_IDLE;
          s_nxt.sel_n = 1'b1;
          s_nxt.done = 1'b1;  // done set wins over read clear
        end else begin
          s_nxt.st = H_LOW;
        end
      end
      default: s_nxt.st = H_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.st <= H_IDLE;
      s_r.sel_n <= 1'b1;
      s_r.nbits <= 5'(rxf_pkg::THRESH_RST);
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign link.sck             = s_r.sck;
  assign link.buffer_select_n = s_r.sel_n;
  assign link.stat_req        = s_r.ctrl[rxf_pkg::CTRL_USESTAT];
  assign pready_o             = acc;
  assign pslverr_o            = acc & s_r.slverr;
  assign prdata_o             = s_r.rdata;
endmodule

/* verification/rxf_link_monitor.sv */
`timescale 1ns/1ps
// pin-level checks on the link between radio side and host controller
module rxf_link_monitor (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sck,
  input wire logic buffer_select_n,
  input wire logic sdo,
  input wire logic buffer_level_flag,
  input wire logic valid_data,
  input wire logic stat_req
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // serial clock only while the buffer is selected
  a_sck_idle_low: assert property (buffer_select_n |-> !sck) else $error("sck while deselected");
  // each clock pulse is short
  a_sck_pulse_short: assert property ($rose(sck) |-> ##[1:4] !sck) else $error("sck stuck high");
  // sdo still steady when the host samples
  a_sdo_held_sample: assert property ($fell(sck) |=> $stable(sdo)) else $error("sdo moved at sample");
  // select falls with the clock parked low
  a_select_before_clk: assert property ($fell(buffer_select_n) |-> !sck && !$past(sck))
    else $error("sck active at select");
  // a read always finishes
  a_read_ends: assert property ($fell(buffer_select_n) |-> ##[1:400] buffer_select_n)
    else $error("read never ended");
  // flag only drops while bits are shifted out
  a_flag_falls_reading: assert property ($fell(buffer_level_flag) |-> !buffer_select_n)
    else $error("flag dropped outside read");
  // flag is low once the last bit went out
  a_flag_low_after: assert property ($rose(buffer_select_n) |-> !buffer_level_flag)
    else $error("flag high after read");
  // status-first mode does not change within a read
  a_stat_mode_steady: assert property (!buffer_select_n && !$fell(buffer_select_n) |-> $stable(stat_req))
    else $error("stat_req moved in read");
  c_valid_seen: cover property ($rose(valid_data));
  c_stat_read: cover property ($fell(buffer_select_n) && stat_req);
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
// drives both ends of the receive link and checks what comes out
module testbench;
  logic        core_clk_i, rst_i, ce_i, bit_stb_i, raw_bit_i, cr_lock_i, rssi_i, rx_buffer_enable_i;
  logic        sync_gate_i, vd_en_i, vd_pin_sel_i, osc_en_i, afa_en_i, afa_auto_i, afa_strobe_i;
  logic        psel, penable, pwrite, pready, pslverr, data_pin_o, rclk_pin_o, host_clk_o;
  logic [3:0]  thresh_i, cap_i;
  logic [2:0]  dqd_thresh_i, clk_div_sel_i;
  logic [4:0]  afa_meas_i, afa_off_o, cap_load_o;
  logic [1:0]  afa_range_i;
  logic [9:0]  fcw_i, fcw_o;
  logic [15:0] status_bits_i, d;
  logic [7:0]  paddr, seed;
  logic        hv;
  logic [31:0] pwdata, prdata;
  logic [32:0] exp_q[$];
  int          bad_count, cmp_count, n, k;
  int          dv[8] = '{1, 2, 3, 4, 5, 8, 16, 32};
  rxf_pkg::rxf_vd_mode_type vd_mode_i;
  rxf_link_if link();
  rxf_dev u_rxf_dev (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .link(link), .bit_stb_i(bit_stb_i),
    .raw_bit_i(raw_bit_i), .cr_lock_i(cr_lock_i), .rssi_i(rssi_i), .rx_buffer_enable_i(rx_buffer_enable_i),
    .sync_gate_i(sync_gate_i), .thresh_i(thresh_i), .dqd_thresh_i(dqd_thresh_i), .vd_en_i(vd_en_i),
    .vd_mode_i(vd_mode_i), .vd_pin_sel_i(vd_pin_sel_i), .afa_en_i(afa_en_i), .afa_auto_i(afa_auto_i),
    .afa_strobe_i(afa_strobe_i), .afa_meas_i(afa_meas_i), .afa_range_i(afa_range_i), .fcw_i(fcw_i),
    .cap_i(cap_i), .clk_div_sel_i(clk_div_sel_i), .osc_en_i(osc_en_i), .status_bits_i(status_bits_i),
    .data_pin_o(data_pin_o), .rclk_pin_o(rclk_pin_o), .fcw_o(fcw_o), .afa_off_o(afa_off_o),
    .cap_load_o(cap_load_o), .host_clk_o(host_clk_o));
  rxf_host u_rxf_host (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .link(link), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .pslverr_o(pslverr), .prdata_o(prdata));
  rxf_link_monitor u_rxf_link_monitor (.core_clk_i(core_clk_i), .rst_i(rst_i), .sck(link.sck),
    .buffer_select_n(link.buffer_select_n), .sdo(link.sdo), .buffer_level_flag(link.buffer_level_flag),
    .valid_data(link.valid_data), .stat_req(link.stat_req));
  ////////////////////////////////////////
  // compare, count, report
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] e);
    cmp_count++;
    if (seen !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic nxt(output logic [15:0] v);
    seed = lfsr(seed);
    v[15:8] = seed;
    seed = lfsr(seed);
    v[7:0] = seed;
  endtask
  // one apb transfer; reads leave their expected value in the queue
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [32:0] e);
    if (!wr) exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // read results are judged as they appear on the bus
  always @(posedge core_clk_i) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) chk("unexpected read", 33'h0, 33'h1);
      else chk("read data", {pslverr, prdata}, exp_q.pop_front());
    end
  end
  // serial bits, msb first, one strobe every four cycles
  task automatic send(input logic [15:0] v, input int cnt);
    for (int i = cnt - 1; i >= 0; i--) begin
      raw_bit_i <= v[i];
      bit_stb_i <= 1'b1;
      cr_lock_i <= seed[0];
      rssi_i <= seed[1];
      seed = lfsr(seed);
      @(posedge core_clk_i);
      bit_stb_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
    end
  endtask
  task automatic rd_buf(input logic [4:0] c, input logic st, input logic [31:0] e);
    apb(1'b1, rxf_pkg::REG_CMD, {27'h0, c}, 33'h0);
    apb(1'b1, rxf_pkg::REG_CTRL, {30'h0, st, 1'b1}, 33'h0);
    n = 0;
    while (link.buffer_select_n !== 1'b1 && n < 500) begin
      @(posedge core_clk_i);
      n++;
    end
    apb(1'b0, rxf_pkg::REG_DATA, 32'h0, {1'b0, e});
  endtask
  // fill to the level, check the flag, drain and check again
  task automatic fill(input logic [3:0] t, input int nn, input logic st);
    logic [31:0] e;
    thresh_i <= t;
    nxt(d);
    e = st ? {status_bits_i, d} : {16'h0, d} & ((32'h1 << nn) - 32'h1);
    send(d >> (nn - t + 1), t - 1);
    chk("flag below level", {32'h0, link.buffer_level_flag}, 33'h0);
    send(d, nn - t + 1);
    chk("flag at level", {32'h0, link.buffer_level_flag}, 33'h1);
    rd_buf(5'(nn), st, e);
    chk("flag drained", {32'h0, link.buffer_level_flag}, 33'h0);
    $display("test fill level %0d done", t);
  endtask
  task automatic rise(output int c);
    logic pv;
    c = 0;
    do begin
      pv = host_clk_o;
      @(posedge core_clk_i);
      c++;
    end while (!(pv === 1'b0 && host_clk_o === 1'b1) && c < 200);
  endtask
  task automatic afa_pulse(input logic [4:0] m);
    afa_meas_i <= m;
    afa_strobe_i <= 1'b1;
    @(posedge core_clk_i);
    afa_strobe_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
  endtask
  ////////////////////////////////////////
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    bad_count++;
    close_out();
  end
  initial begin
    {rst_i, ce_i, rx_buffer_enable_i, osc_en_i} = 4'hf;
    {bit_stb_i, raw_bit_i, cr_lock_i, rssi_i, sync_gate_i, vd_en_i, vd_pin_sel_i} = 7'h00;
    {afa_en_i, afa_auto_i, afa_strobe_i, psel, penable, pwrite} = 6'h00;
    {thresh_i, cap_i, dqd_thresh_i, clk_div_sel_i, afa_meas_i, afa_range_i} = 21'h80300;
    {fcw_i, paddr, pwdata} = 50'h0;
    seed = 8'h27;
    status_bits_i = 16'h0;
    vd_mode_i = rxf_pkg::VD_MED;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    apb(1'b0, rxf_pkg::REG_CMD, 32'h0, 33'h8);
    apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
    sync_gate_i <= 1'b1;
    vd_pin_sel_i <= 1'b1;
    send(16'haaaa, 16);
    chk("valid before sync", {32'h0, link.valid_data}, 33'h0);
    send(rxf_pkg::SYNC_WORD, 16);
    chk("valid at sync", {32'h0, link.valid_data}, 33'h1);
    chk("no fill before sync", {32'h0, link.buffer_level_flag}, 33'h0);
    fill(4'h8, 8, 1'b0);
    sync_gate_i <= 1'b0;
    nxt(d);
    status_bits_i <= d;
    fill(4'h1, 1, 1'b0);
    fill(4'hf, 16, 1'b1);
    for (k = 0; k < 16; k++) begin
      cap_i <= 4'(k);
      @(posedge core_clk_i);
      chk("load cap", 33'(cap_load_o), 33'(k + 1));
    end
    for (k = 0; k < 8; k++) begin
      clk_div_sel_i <= 3'(k);
      repeat (80) @(posedge core_clk_i);
      rise(n);
      rise(n);
      chk("clock period", 33'(n), 33'(dv[k] * 2));
    end
    clk_div_sel_i <= 3'h0;
    repeat (80) @(posedge core_clk_i);
    osc_en_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    k = 0;
    hv = host_clk_o;
    repeat (600) begin
      @(posedge core_clk_i);
      if (hv === 1'b1 && host_clk_o === 1'b0) k++;
      hv = host_clk_o;
    end
    chk("clocks after stop", 33'(k), 33'd196);
    chk("clock parked", {32'h0, host_clk_o}, 33'h0);
    osc_en_i <= 1'b1;
    fcw_i <= 10'h100;
    afa_en_i <= 1'b1;
    afa_pulse(5'h01);
    chk("offset one", 33'(afa_off_o), 33'h1);
    afa_pulse(5'h0f);
    chk("offset clamped", 33'(afa_off_o), 33'h2);
    chk("trimmed word", 33'(fcw_o), 33'h102);
    afa_en_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    chk("untrimmed word", 33'(fcw_o), 33'h100);
    afa_en_i <= 1'b1;
    afa_auto_i <= 1'b1;
    afa_meas_i <= 5'h1f;
    repeat (3) @(posedge core_clk_i);
    chk("auto offset", 33'(afa_off_o), 33'h1f);
    afa_meas_i <= 5'h18;
    repeat (3) @(posedge core_clk_i);
    chk("low clamp", 33'(afa_off_o), 33'h1e);
    afa_auto_i <= 1'b0;
    rx_buffer_enable_i <= 1'b0;
    raw_bit_i <= 1'b1;
    bit_stb_i <= 1'b1;
    @(posedge core_clk_i);
    bit_stb_i <= 1'b0;
    @(posedge core_clk_i);
    chk("raw data pin", {32'h0, data_pin_o}, 33'h1);
    chk("recovered clock pin", {32'h0, rclk_pin_o}, 33'h1);
    @(posedge core_clk_i);
    chk("clock pin idle", {32'h0, rclk_pin_o}, 33'h0);
    $display("test clock and trim done");
    close_out();
  end
endmodule
